// ### src/tcc_defs.vh
// constants for the type-c configuration channel controller
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

// ----------------------------------------------------------------------
// termination codes
// ----------------------------------------------------------------------
`define TCC_TERM_OPEN      2'h0
`define TCC_TERM_RA        2'h1
`define TCC_TERM_RD        2'h2

// ----------------------------------------------------------------------
// port roles
// ----------------------------------------------------------------------
`define TCC_ROLE_SOURCE    2'h0
`define TCC_ROLE_SINK      2'h1
`define TCC_ROLE_DUAL      2'h2

// ----------------------------------------------------------------------
// advertised current levels (pull-up current select)
// ----------------------------------------------------------------------
`define TCC_ADV_DEFAULT    2'h0
`define TCC_ADV_1P5        2'h1
`define TCC_ADV_3P0        2'h2

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define TCC_CLK_MHZ        125
`define TCC_DEBOUNCE_US    100
`define TCC_DEBOUNCE_CYC   (`TCC_DEBOUNCE_US * `TCC_CLK_MHZ)
`define TCC_TOGGLE_US      50000
`define TCC_TOGGLE_CYC     (`TCC_TOGGLE_US * `TCC_CLK_MHZ)
`define TCC_SAFE0_MS       650
`define TCC_SAFE0_CYC      (`TCC_SAFE0_MS * 1000 * `TCC_CLK_MHZ)
`define TCC_STRAP_CYC      16

`endif

// ### src/tcc_term_debounce.v
// one pin: comparator outputs to a debounced termination code
`timescale 1ns/10ps
`include "tcc_defs.vh"

module tcc_term_debounce #(
    parameter DEBOUNCE_CYC = `TCC_DEBOUNCE_CYC
) (
    input  wire       i_clk_sys,
    input  wire       i_rst_n,
    input  wire       i_below_detach,
    input  wire       i_below_cable,
    output reg  [1:0] o_term
);

    reg  [1:0]  raw;
    reg  [1:0]  cand_q;
    reg  [23:0] cnt_q;

    // below active-cable threshold means Ra, else below detach is Rd
    always @* begin
        if (i_below_cable) begin
            raw = `TCC_TERM_RA;
        end else if (i_below_detach) begin
            raw = `TCC_TERM_RD;
        end else begin
            raw = `TCC_TERM_OPEN;
        end
    end

    // a code must hold for the whole window before it is published
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cand_q <= `TCC_TERM_OPEN;
            cnt_q  <= 24'h000000;
            o_term <= `TCC_TERM_OPEN;
        end else if (raw != cand_q) begin
            cand_q <= raw;
            cnt_q  <= 24'h000000;
        end else if (cnt_q == DEBOUNCE_CYC[23:0] - 24'h000001) begin
            o_term <= cand_q;
        end else begin
            cnt_q  <= cnt_q + 24'h000001;
        end
    end

endmodule

// ### src/tcc_tick.v
// free-running divider giving a one-cycle enable pulse
`timescale 1ns/10ps

module tcc_tick #(
    parameter PERIOD = 1000
) (
    input  wire i_clk_sys,
    input  wire i_rst_n,
    output reg  o_tick
);

    reg [31:0] cnt_q;

    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_q  <= 32'h00000000;
            o_tick <= 1'b0;
        end else if (cnt_q == PERIOD - 1) begin
            cnt_q  <= 32'h00000000;
            o_tick <= 1'b1;
        end else begin
            cnt_q  <= cnt_q + 32'h00000001;
            o_tick <= 1'b0;
        end
    end

endmodule

// ### src/tcc_cc_ctrl.v
// type-c cc attach, vconn, fast swap and vbus discharge control
`timescale 1ns/10ps
`include "tcc_defs.vh"

module tcc_cc_ctrl #(
    parameter TOGGLE_CYC = `TCC_TOGGLE_CYC,
    parameter SAFE0_CYC  = `TCC_SAFE0_CYC
) (
    input  wire       i_clk_sys,
    input  wire       i_rst_n,
    input  wire [1:0] i_role,
    input  wire [1:0] i_adv_level,
    input  wire       i_one_below_detach,
    input  wire       i_one_below_cable,
    input  wire       i_two_below_detach,
    input  wire       i_two_below_cable,
    input  wire [1:0] i_one_sink_level,
    input  wire [1:0] i_two_sink_level,
    input  wire       i_vbus_present,
    input  wire       i_fast_swap_en,
    input  wire       i_one_below_swap,
    input  wire       i_two_below_swap,
    input  wire       i_swap_request,
    input  wire       i_vconn_en,
    input  wire       i_vconn_input_good,
    input  wire       i_hv_path_on,
    input  wire       i_vbus_above_safe5,
    input  wire       i_vbus_above_safe0,
    input  wire       i_go_safe0,
    input  wire       i_app_running,
    input  wire       i_sink_power_needed,
    input  wire [1:0] i_bus_power_strap,
    input  wire       i_wait_ext_cfg,
    input  wire       i_ext_sink_req,
    output reg        o_attached,
    output reg        o_orient_two,
    output reg        o_vbus_en,
    output reg        o_vconn_one,
    output reg        o_vconn_two,
    output reg        o_vconn_limit_en,
    output reg  [1:0] o_source_current,
    output reg        o_pullup_on,
    output reg        o_trimmed_pd_on,
    output reg        o_dead_batt_pd_hiz,
    output reg        o_debug_acc,
    output reg        o_audio_acc,
    output reg        o_cable_only,
    output reg  [1:0] o_offered_current,
    output reg        o_swap_detected,
    output reg        o_swap_pd_one,
    output reg        o_swap_pd_two,
    output reg        o_acting_source,
    output reg        o_discharge_on,
    output reg        o_safe0_timeout,
    output reg  [1:0] o_strap_value,
    output reg        o_strap_valid,
    output reg        o_ext_sink_path
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    localparam [6:0] ST_UNATT  = 7'h01;
    localparam [6:0] ST_CABLE  = 7'h02;
    localparam [6:0] ST_SRC    = 7'h04;
    localparam [6:0] ST_DEBUG  = 7'h08;
    localparam [6:0] ST_AUDIO  = 7'h10;
    localparam [6:0] ST_SNK_W  = 7'h20;
    localparam [6:0] ST_SNK    = 7'h40;

    // ------------------------------------------------------------------
    // pin terminations
    // ------------------------------------------------------------------
    wire [1:0] t_one;
    wire [1:0] t_two;
    wire       tog_tick;

    tcc_term_debounce u_deb_one (
        .i_clk_sys      (i_clk_sys),
        .i_rst_n        (i_rst_n),
        .i_below_detach (i_one_below_detach),
        .i_below_cable  (i_one_below_cable),
        .o_term         (t_one)
    );

    tcc_term_debounce u_deb_two (
        .i_clk_sys      (i_clk_sys),
        .i_rst_n        (i_rst_n),
        .i_below_detach (i_two_below_detach),
        .i_below_cable  (i_two_below_cable),
        .o_term         (t_two)
    );

    tcc_tick #(
        .PERIOD (TOGGLE_CYC)
    ) u_tog (
        .i_clk_sys (i_clk_sys),
        .i_rst_n   (i_rst_n),
        .o_tick    (tog_tick)
    );

    reg  [6:0]  st_q;
    reg  [6:0]  st_d;
    reg         orient_d;
    reg         src_phase_q;
    reg         src_mode_q;
    reg         src_mode_d;
    reg  [31:0] safe0_cnt_q;
    reg  [4:0]  strap_cnt_q;
    reg         dead_batt_q;

    wire src_side = src_mode_q;
    wire one_open = (t_one == `TCC_TERM_OPEN);
    wire two_open = (t_two == `TCC_TERM_OPEN);
    wire one_rd   = (t_one == `TCC_TERM_RD);
    wire two_rd   = (t_two == `TCC_TERM_RD);
    wire one_ra   = (t_one == `TCC_TERM_RA);
    wire two_ra   = (t_two == `TCC_TERM_RA);
    wire swap_in  = o_orient_two ? i_two_below_swap : i_one_below_swap;

    // ------------------------------------------------------------------
    // attach state machine
    // ------------------------------------------------------------------
    always @* begin
        st_d       = st_q;
        orient_d   = o_orient_two;
        src_mode_d = src_mode_q;
        case (st_q)
            ST_UNATT: begin
                if (!src_side) begin
                    st_d = ST_SNK_W;
                end else if (one_rd && two_rd) begin
                    st_d = ST_DEBUG;
                end else if (one_ra && two_ra) begin
                    st_d = ST_AUDIO;
                end else if (one_rd && (two_open || two_ra)) begin
                    st_d     = ST_SRC;
                    orient_d = 1'b0;
                end else if (two_rd && (one_open || one_ra)) begin
                    st_d     = ST_SRC;
                    orient_d = 1'b1;
                end else if (one_ra || two_ra) begin
                    st_d = ST_CABLE;
                end
            end
            ST_CABLE: begin
                // open pin watched for sink, Ra pin for removal
                if (one_rd || two_rd) begin
                    st_d = ST_UNATT;
                end else if (one_open && two_open) begin
                    st_d = ST_UNATT;
                end
            end
            ST_SRC: begin
                // only the Rd pin is watched; the Ra pin is ignored
                if (o_orient_two ? two_open : one_open) begin
                    st_d = ST_UNATT;
                end else if (i_fast_swap_en && i_swap_request) begin
                    st_d       = ST_SNK;
                    src_mode_d = 1'b0;
                end
            end
            ST_DEBUG: begin
                if (one_open || two_open) begin
                    st_d = ST_UNATT;
                end
            end
            ST_AUDIO: begin
                if (one_open || two_open) begin
                    st_d = ST_UNATT;
                end
            end
            ST_SNK_W: begin
                if (src_side) begin
                    st_d = ST_UNATT;
                end else if (i_vbus_present) begin
                    st_d     = ST_SNK;
                    orient_d = (i_two_sink_level > i_one_sink_level);
                end
            end
            ST_SNK: begin
                if (i_fast_swap_en && swap_in) begin
                    st_d       = ST_SRC;
                    src_mode_d = 1'b1;
                end else if (!i_vbus_present) begin
                    st_d = ST_UNATT;
                end
            end
            default: begin
                st_d = ST_UNATT;
            end
        endcase
    end

    // role: fixed roles follow the input, dual role toggles while idle
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            st_q        <= ST_UNATT;
            src_phase_q <= 1'b0;
            src_mode_q  <= 1'b0;
        end else begin
            st_q <= st_d;
            if (st_q == ST_UNATT || st_q == ST_SNK_W) begin
                if (i_role == `TCC_ROLE_DUAL) begin
                    if (tog_tick) begin
                        src_phase_q <= ~src_phase_q;
                    end
                    src_mode_q <= src_phase_q;
                end else begin
                    src_mode_q <= (i_role == `TCC_ROLE_SOURCE);
                end
            end else begin
                src_mode_q <= src_mode_d;
            end
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_attached        <= 1'b0;
            o_orient_two      <= 1'b0;
            o_vbus_en         <= 1'b0;
            o_vconn_one       <= 1'b0;
            o_vconn_two       <= 1'b0;
            o_vconn_limit_en  <= 1'b0;
            o_source_current  <= `TCC_ADV_DEFAULT;
            o_pullup_on       <= 1'b0;
            o_trimmed_pd_on   <= 1'b0;
            o_debug_acc       <= 1'b0;
            o_audio_acc       <= 1'b0;
            o_cable_only      <= 1'b0;
            o_offered_current <= `TCC_ADV_DEFAULT;
            o_swap_detected   <= 1'b0;
            o_swap_pd_one     <= 1'b0;
            o_swap_pd_two     <= 1'b0;
            o_acting_source   <= 1'b0;
        end else begin
            o_orient_two     <= orient_d;
            o_attached       <= (st_d == ST_SRC) || (st_d == ST_SNK) ||
                                (st_d == ST_DEBUG) || (st_d == ST_AUDIO);
            // no power in unattached or cable-only states
            o_vbus_en        <= (st_d == ST_SRC);
            o_source_current <= i_adv_level;
            o_pullup_on      <= src_mode_d;
            o_trimmed_pd_on  <= !src_mode_d &&
                                !dead_batt_q;
            o_debug_acc      <= (st_d == ST_DEBUG);
            o_audio_acc      <= (st_d == ST_AUDIO);
            o_cable_only     <= (st_d == ST_CABLE);
            o_acting_source  <= src_mode_d;
            if (st_q == ST_SNK) begin
                o_offered_current <= o_orient_two ? i_two_sink_level
                                                  : i_one_sink_level;
            end
            // switch closes only on good input; a later sag leaves it
            if (st_d != ST_SRC || !i_vconn_en) begin
                o_vconn_one <= 1'b0;
                o_vconn_two <= 1'b0;
                o_vconn_limit_en <= 1'b0;
            end else if (!o_vconn_one && !o_vconn_two &&
                         i_vconn_input_good) begin
                o_vconn_one <= orient_d && one_ra;
                o_vconn_two <= !orient_d && two_ra;
                o_vconn_limit_en <= orient_d ? one_ra : two_ra;
            end
            // set wins over the clear when a new swap arrives
            if (st_q == ST_SNK && i_fast_swap_en && swap_in) begin
                o_swap_detected <= 1'b1;
            end else if (st_q != ST_SNK && st_q != ST_SRC) begin
                o_swap_detected <= 1'b0;
            end
            o_swap_pd_one <= (st_q == ST_SRC) && i_fast_swap_en &&
                             i_swap_request && !o_orient_two;
            o_swap_pd_two <= (st_q == ST_SRC) && i_fast_swap_en &&
                             i_swap_request && o_orient_two;
        end
    end

    // ------------------------------------------------------------------
    // vbus discharge
    // ------------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_discharge_on  <= 1'b0;
            o_safe0_timeout <= 1'b0;
            safe0_cnt_q     <= 32'h00000000;
        end else begin
            if (i_go_safe0) begin
                o_discharge_on <= !i_hv_path_on &&
                                  i_vbus_above_safe0;
            end else begin
                o_discharge_on <= !i_hv_path_on &&
                                  i_vbus_above_safe5;
            end
            // count toward the discharge limit; flag if it runs out
            if (!i_go_safe0 || !i_vbus_above_safe0) begin
                safe0_cnt_q <= 32'h00000000;
            end else if (safe0_cnt_q == SAFE0_CYC - 1) begin
                o_safe0_timeout <= 1'b1;
            end else begin
                safe0_cnt_q <= safe0_cnt_q + 32'h00000001;
            end
            if (!i_go_safe0) begin
                o_safe0_timeout <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // dead battery and strap
    // ------------------------------------------------------------------
    always @(posedge i_clk_sys or negedge i_rst_n) begin
        if (!i_rst_n) begin
            dead_batt_q        <= 1'b1;
            o_dead_batt_pd_hiz <= 1'b1;
            strap_cnt_q        <= 5'h00;
            o_strap_value      <= 2'h0;
            o_strap_valid      <= 1'b0;
            o_ext_sink_path    <= 1'b0;
        end else begin
            // untrimmed pull-down stays until firmware takes over
            if (i_app_running) begin
                dead_batt_q <= 1'b0;
            end
            o_dead_batt_pd_hiz <= dead_batt_q &&
                                  !(i_app_running &&
                                    !i_sink_power_needed);
            // strap sampled once after reset release settles
            if (!o_strap_valid) begin
                if (strap_cnt_q == `TCC_STRAP_CYC) begin
                    o_strap_value <= i_bus_power_strap;
                    o_strap_valid <= 1'b1;
                end else begin
                    strap_cnt_q <= strap_cnt_q + 5'h01;
                end
            end
            o_ext_sink_path <= i_wait_ext_cfg &&
                               i_ext_sink_req;
        end
    end

endmodule

// ### test/tcc_cc_sva.sv
// port assertions for the cc attach and power controller
`timescale 1ns/10ps
module tcc_cc_sva (
    input wire       i_clk_sys,
    input wire       i_rst_n,
    input wire [1:0] i_adv_level,
    input wire       i_vconn_input_good,
    input wire       i_hv_path_on,
    input wire       i_vbus_above_safe5,
    input wire       i_vbus_above_safe0,
    input wire       i_go_safe0,
    input wire [1:0] i_bus_power_strap,
    input wire       o_attached,
    input wire       o_orient_two,
    input wire       o_vbus_en,
    input wire       o_vconn_one,
    input wire       o_vconn_two,
    input wire       o_vconn_limit_en,
    input wire [1:0] o_source_current,
    input wire       o_pullup_on,
    input wire       o_debug_acc,
    input wire       o_audio_acc,
    input wire       o_cable_only,
    input wire       o_swap_pd_one,
    input wire       o_swap_pd_two,
    input wire       o_discharge_on,
    input wire [1:0] o_strap_value,
    input wire       o_strap_valid
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    a_vconn_one_side: assert property (!(o_vconn_one && o_vconn_two))
        else $error("vconn driven on both pins");
    a_vconn_needs_good: assert property ($rose(o_vconn_one || o_vconn_two)
        |-> $past(i_vconn_input_good)) else $error("vconn closed on bad input");
    a_vconn_limited: assert property ((o_vconn_one || o_vconn_two)
        |-> o_vconn_limit_en) else $error("vconn without current limit");
    a_vbus_attached: assert property (o_vbus_en |-> o_attached)
        else $error("vbus on while not attached");
    a_cable_no_power: assert property (o_cable_only
        |-> !(o_vbus_en || o_vconn_one || o_vconn_two))
        else $error("power applied to cable only");
    a_acc_exclusive: assert property (!(o_debug_acc && o_audio_acc))
        else $error("two accessory states at once");
    a_pullup_level: assert property (o_pullup_on && $past(o_pullup_on)
        && $stable(i_adv_level) |-> o_source_current == i_adv_level)
        else $error("pull-up current does not match level");
    a_discharge_on: assert property (!i_hv_path_on && i_vbus_above_safe5
        |=> o_discharge_on) else $error("no discharge above safe5");
    a_discharge_off: assert property (!i_vbus_above_safe5 && !i_go_safe0
        |=> !o_discharge_on) else $error("discharge held at safe5");
    a_safe0_hold: assert property (i_go_safe0 && !i_hv_path_on
        && i_vbus_above_safe0 |=> o_discharge_on)
        else $error("discharge released above safe0");
    a_strap_value: assert property ($rose(o_strap_valid)
        |-> o_strap_value == $past(i_bus_power_strap))
        else $error("strap value not captured");
    a_swap_pd_pin: assert property (o_swap_pd_one
        |-> !o_orient_two && !o_swap_pd_two) else $error("swap pull-down pin");
endmodule

bind tcc_cc_ctrl tcc_cc_sva tcc_cc_sva_inst (.*);

// ### test/tcc_partner.sv
// far-side model: partner terminations as the pin comparators see them
`timescale 1ns/10ps
`include "tcc_defs.vh"
module tcc_partner (
    input  wire [1:0] i_term_one,
    input  wire [1:0] i_term_two,
    input  wire       i_src_on,
    input  wire       i_swap_sig,
    output wire       o_one_below_detach,
    output wire       o_one_below_cable,
    output wire       o_two_below_detach,
    output wire       o_two_below_cable,
    output wire [1:0] o_one_level,
    output wire [1:0] o_two_level,
    output wire       o_vbus_present,
    output wire       o_one_below_swap,
    output wire       o_two_below_swap
);
    // any pull-down sits below detach
    assign o_one_below_detach = (i_term_one != `TCC_TERM_OPEN);
    assign o_two_below_detach = (i_term_two != `TCC_TERM_OPEN);
    // ra, the lower one, is also below cable
    assign o_one_below_cable = (i_term_one == `TCC_TERM_RA);
    assign o_two_below_cable = (i_term_two == `TCC_TERM_RA);
    // partner source pulls up pin one, 3 a
    assign o_one_level = i_src_on ? `TCC_ADV_3P0 : `TCC_ADV_DEFAULT;
    assign o_two_level = `TCC_ADV_DEFAULT;
    assign o_vbus_present = i_src_on;
    assign o_one_below_swap = i_swap_sig;
    assign o_two_below_swap = 1'b0;
endmodule

// ### test/tb.sv
// self-checking bench for the cc attach and power controller
`timescale 1ns/10ps
`include "tcc_defs.vh"
module tb;
    typedef struct packed {
        logic [1:0] t1, t2, att, ori, vb, v1, v2, dbg, cab;
    } tcc_row_t;
    logic i_clk_sys, i_rst_n, i_fast_swap_en, i_swap_request, i_vconn_en;
    logic i_vconn_input_good, i_hv_path_on, i_vbus_above_safe5, i_go_safe0;
    logic i_vbus_above_safe0, i_app_running, i_sink_power_needed;
    logic i_wait_ext_cfg, i_ext_sink_req, src_on, swap_sig, last;
    logic [1:0] i_role, i_adv_level, i_bus_power_strap, term_one, term_two;
    wire i_one_below_detach, i_one_below_cable, i_two_below_detach;
    wire i_two_below_cable, i_vbus_present, i_one_below_swap, i_two_below_swap;
    wire [1:0] i_one_sink_level, i_two_sink_level;
    wire o_attached, o_orient_two, o_vbus_en, o_vconn_one, o_vconn_two;
    wire o_vconn_limit_en, o_pullup_on, o_trimmed_pd_on, o_dead_batt_pd_hiz;
    wire o_debug_acc, o_audio_acc, o_cable_only, o_swap_detected;
    wire o_swap_pd_one, o_swap_pd_two, o_acting_source, o_discharge_on;
    wire o_safe0_timeout, o_strap_valid, o_ext_sink_path;
    wire [1:0] o_source_current, o_offered_current, o_strap_value;
    tcc_row_t rows [0:4];
    int mismatches, compares, i, k, n;

    tcc_cc_ctrl #(.TOGGLE_CYC(20), .SAFE0_CYC(50)) tcc_cc_ctrl_inst (
        .i_clk_sys, .i_rst_n, .i_role, .i_adv_level, .i_one_below_detach,
        .i_one_below_cable, .i_two_below_detach, .i_two_below_cable,
        .i_one_sink_level, .i_two_sink_level, .i_vbus_present, .i_fast_swap_en,
        .i_one_below_swap, .i_two_below_swap, .i_swap_request, .i_vconn_en,
        .i_vconn_input_good, .i_hv_path_on, .i_vbus_above_safe5,
        .i_vbus_above_safe0, .i_go_safe0, .i_app_running, .i_sink_power_needed,
        .i_bus_power_strap, .i_wait_ext_cfg, .i_ext_sink_req, .o_attached,
        .o_orient_two, .o_vbus_en, .o_vconn_one, .o_vconn_two, .o_vconn_limit_en,
        .o_source_current, .o_pullup_on, .o_trimmed_pd_on, .o_dead_batt_pd_hiz,
        .o_debug_acc, .o_audio_acc, .o_cable_only, .o_offered_current,
        .o_swap_detected, .o_swap_pd_one, .o_swap_pd_two, .o_acting_source,
        .o_discharge_on, .o_safe0_timeout, .o_strap_value, .o_strap_valid,
        .o_ext_sink_path
    );
    tcc_partner tcc_partner_inst (
        .i_term_one(term_one), .i_term_two(term_two), .i_src_on(src_on),
        .i_swap_sig(swap_sig), .o_one_below_detach(i_one_below_detach),
        .o_one_below_cable(i_one_below_cable),
        .o_two_below_detach(i_two_below_detach),
        .o_two_below_cable(i_two_below_cable), .o_one_level(i_one_sink_level),
        .o_two_level(i_two_sink_level), .o_vbus_present(i_vbus_present),
        .o_one_below_swap(i_one_below_swap), .o_two_below_swap(i_two_below_swap)
    );

    always #4 i_clk_sys = ~i_clk_sys;

    // ------------
    // shared tasks
    // ------------
    task end_of_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // expected 3: don't care
    task chk(input logic [1:0] got, input logic [1:0] exp);
        if (exp !== 2'h3) begin
            compares++;
            if (got !== exp) begin
                mismatches++;
                $display("MISMATCH t=%0t got %b exp %b", $time, got, exp);
            end
        end
    endtask
    task wait_cyc(input int c);
        repeat (c) @(posedge i_clk_sys);
        #1;
    endtask
    task do_reset(input logic [1:0] r);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b0;
        i_role <= r;
        {i_swap_request, src_on, swap_sig} <= 3'h0;
        wait_cyc(20);
        chk(o_dead_batt_pd_hiz, 2'h1);
        chk(o_attached, 2'h0);
        @(posedge i_clk_sys);
        i_rst_n <= 1'b1;
        $display("test reset done");
    endtask
    task run_row(input tcc_row_t r);
        @(posedge i_clk_sys);
        term_one <= r.t1;
        term_two <= r.t2;
        wait_cyc(12510);
        chk(o_attached, r.att);
        chk(o_orient_two, r.ori);
        chk(o_vbus_en, r.vb);
        chk(o_vconn_one, r.v1);
        chk(o_vconn_two, r.v2);
        chk(o_debug_acc, r.dbg);
        chk(o_cable_only, r.cab);
    endtask

    initial begin
        i_clk_sys = 1'b0;
        {i_rst_n, i_fast_swap_en, i_swap_request, i_go_safe0} = 4'h0;
        {i_vbus_above_safe5, i_vbus_above_safe0, i_app_running} = 3'h0;
        {i_wait_ext_cfg, i_ext_sink_req, src_on, swap_sig} = 4'h0;
        {i_vconn_en, i_vconn_input_good, i_hv_path_on} = 3'h7;
        i_sink_power_needed = 1'b1;
        {i_role, i_adv_level} = {`TCC_ROLE_SOURCE, `TCC_ADV_3P0};
        i_bus_power_strap = 2'h2;
        {term_one, term_two} = {`TCC_TERM_OPEN, `TCC_TERM_OPEN};
        {mismatches, compares} = 64'h0;
        rows[0] = {`TCC_TERM_RA, `TCC_TERM_OPEN, 14'h0C01};
        rows[1] = {`TCC_TERM_RA, `TCC_TERM_RD, 14'h1540};
        rows[2] = {`TCC_TERM_RD, `TCC_TERM_RD, 14'h1F04};
        rows[3] = {`TCC_TERM_RD, `TCC_TERM_OPEN, 14'h1100};
        rows[4] = {`TCC_TERM_OPEN, `TCC_TERM_OPEN, 14'h0C00};
        do_reset(`TCC_ROLE_SOURCE);
        wait_cyc(30);
        chk(o_strap_valid, 2'h1);
        chk(o_strap_value, 2'h2);
        for (i = 0; i < 3; i++) begin
            @(posedge i_clk_sys);
            i_adv_level <= i[1:0];
            wait_cyc(4);
            chk(o_source_current, i[1:0]);
        end
        for (i = 0; i < 4; i++) begin
            run_row(rows[i]);
            if (i == 1) begin
                @(posedge i_clk_sys);
                i_vconn_input_good <= 1'b0;
                wait_cyc(5);
                chk(o_vconn_one, 2'h1);
                i_vconn_input_good <= 1'b1;
            end
            if (i < 3)
                run_row(rows[4]);
            $display("test row %0d done", i);
        end
        // -------------
        // awkward cases
        // -------------
        @(posedge i_clk_sys);
        {i_fast_swap_en, i_swap_request} <= 2'h3;
        for (k = 0; k < 50 && o_acting_source !== 1'b0; k++) wait_cyc(1);
        chk(o_swap_pd_one, 2'h1);
        chk(o_acting_source, 2'h0);
        @(posedge i_clk_sys);
        {i_hv_path_on, i_vbus_above_safe5, i_vbus_above_safe0} <= 3'h3;
        {i_wait_ext_cfg, i_ext_sink_req} <= 2'h3;
        wait_cyc(3);
        chk(o_discharge_on, 2'h1);
        chk(o_ext_sink_path, 2'h1);
        {i_vbus_above_safe5, i_go_safe0} <= 2'h1;
        wait_cyc(3);
        chk(o_discharge_on, 2'h1);
        wait_cyc(60);
        chk(o_safe0_timeout, 2'h1);
        {i_vbus_above_safe0, i_go_safe0} <= 2'h0;
        {i_app_running, i_sink_power_needed} <= 2'h2;
        wait_cyc(3);
        chk(o_discharge_on, 2'h0);
        chk(o_dead_batt_pd_hiz, 2'h0);
        $display("test power done");
        do_reset(`TCC_ROLE_SINK);
        wait_cyc(5);
        chk(o_trimmed_pd_on, 2'h1);
        src_on <= 1'b1;
        for (k = 0; k < 13000 && o_attached !== 1'b1; k++) wait_cyc(1);
        chk(o_attached, 2'h1);
        swap_sig <= 1'b1;
        for (k = 0; k < 50 && o_acting_source !== 1'b1; k++) wait_cyc(1);
        chk(o_swap_detected, 2'h1);
        chk(o_acting_source, 2'h1);
        chk(o_offered_current, `TCC_ADV_3P0);
        $display("test sink done");
        do_reset(`TCC_ROLE_DUAL);
        {n, last} = {32'h0, 1'b0};
        for (k = 0; k < 200; k++) begin
            wait_cyc(1);
            if (o_pullup_on !== last) n++;
            last = o_pullup_on;
        end
        chk((n >= 4) ? 2'h1 : 2'h0, 2'h1);
        $display("test dual done");
        end_of_test;
    end

    initial begin
        repeat (95000) @(posedge i_clk_sys);
        mismatches++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        end_of_test;
    end
endmodule
